// File: inc/fmi_pkg.sv
package fmi_pkg;

  // ----------------------------------------------------------------
  // Execution states of the fault manager
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FMI_IDLE = 3'b001,
    FMI_RUN = 3'b010,
    FMI_FAULT = 3'b100
  } fmi_state_t;

  // AXI response codes
  typedef enum logic [1:0] {
    FMI_RESP_OKAY = 2'b00,
    FMI_RESP_SLVERR = 2'b10
  } fmi_resp_t;

endpackage

// File: inc/fmi_regs.svh
// Summary of operation
// [R1] Sixteen fault feedback lanes feed the fault manager and are readable as plain inputs.
// [R2] The fault manager holds the system execution state and gates the PWM outputs from lanes 0..15 and the interlock.
// [R3] An active enabled fault lane blocks the PWM outputs within 60 ns, 50 ns typical.
// [R4] Lanes idle low and are active high by default, and software may make each one active low.
// [R5] A software mask enables each fault lane on its own, and a disabled lane never triggers.
// [R6] The current fault flag of every source is readable from a fault values register.
// [R7] Asserting the active-low critical-fault input blocks the PWM outputs within 50 ns, 40 ns typical.
// [R8] An active-low critical-fault output reports the block's own internal fault condition.
// [R9] The interlock works both ways: internal faults go out, external triggers come in.
// [R10] The interlock is also carried over the inter-board link, at about 0.2 us per node.
// [R11] While a blocking fault is present all gated PWM outputs are driven low.
`ifndef FMI_REGS_SVH
`define FMI_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define FMI_ADDR_W 8
`define FMI_CTRL_OFS 8'h00
`define FMI_MASK_OFS 8'h04
`define FMI_POL_OFS 8'h08
`define FMI_VALUES_OFS 8'h0c
`define FMI_RAW_OFS 8'h10
`define FMI_LATCH_OFS 8'h14
`define FMI_STATUS_OFS 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FMI_CTRL_RUN_BIT 0
`define FMI_CTRL_ILK_EN_BIT 1
`define FMI_CTRL_LINK_EN_BIT 2
`define FMI_CTRL_CLR_BIT 8
`define FMI_SRC_EXT_BIT 16
`define FMI_SRC_LINK_BIT 17
`define FMI_STAT_BLOCK_BIT 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FMI_CTRL_RST 3'h6
`define FMI_MASK_RST 16'hffff
`define FMI_POL_RST 16'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FMI_CLK_PERIOD_PS 8000
`define FMI_LANE_BLOCK_MAX_NS 60
`define FMI_EXT_BLOCK_MAX_NS 50
`define FMI_LINK_HOP_NS 200
`define FMI_LANE_BLOCK_CYC ((`FMI_LANE_BLOCK_MAX_NS * 1000) / `FMI_CLK_PERIOD_PS)
`define FMI_EXT_BLOCK_CYC ((`FMI_EXT_BLOCK_MAX_NS * 1000) / `FMI_CLK_PERIOD_PS)

`endif

// File: tb/fmi_fault_src.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Far side: gate drivers on the fault lanes and a peer controller
// ----------------------------------------------------------------
module fmi_fault_src (
  // Commands from the bench
  input wire logic [15:0] trip_i,
  input wire logic [15:0] pol_i,
  input wire logic ext_trip_i,
  // Pins towards the block
  output logic [15:0] lanes_o,
  output logic ext_n_o
);
  // An idle lane rests at its pulled-down level unless it is wired active low
  assign lanes_o = trip_i ^ pol_i;
  // The peer pulls the shared interlock low to demand a shutdown
  assign ext_n_o = ~ext_trip_i;
endmodule

`default_nettype wire

// File: tb/fmi_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Port-level checks of the fault manager
// ----------------------------------------------------------------
module fmi_top_assertions #(
  parameter int LANES = 16,
  parameter int PWM_W = 32
) (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Bus handshakes
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Fault pins
  input wire logic ext_critical_fault_in_n_i,
  input wire logic link_fault_i,
  input wire logic critical_fault_out_n_o,
  input wire logic link_fault_o,
  input wire logic [PWM_W-1:0] pwm_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Three sampled edges cover the two synchroniser stages plus the gate
  sequence ext_held;
    (!ext_critical_fault_in_n_i && ce_i) [*3];
  endsequence
  sequence link_held;
    (link_fault_i && ce_i) [*3];
  endsequence
  sequence write_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o && ce_i;
  endsequence

  AST_EXT_BLOCK: assert property (ext_held |=> pwm_o == '0)
    else $error("pwm not blocked by external interlock");
  AST_LINK_BLOCK: assert property (link_held |=> pwm_o == '0)
    else $error("pwm not blocked by link interlock");
  AST_OWN_BLOCK: assert property (!critical_fault_out_n_o |-> pwm_o == '0)
    else $error("pwm active while own fault reported");
  AST_OUT_PAIR: assert property (critical_fault_out_n_o == !link_fault_o)
    else $error("fault outputs disagree");
  AST_B_ANSWER: assert property (write_taken |-> ##[1:2] s_axi_bvalid_o)
    else $error("write response late");
  AST_R_ANSWER: assert property (s_axi_arvalid_i && s_axi_arready_o && ce_i |=> s_axi_rvalid_o)
    else $error("read data late");
  AST_B_STANDS: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
      s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  AST_R_STANDS: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
      s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  AST_AR_REFUSE: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read address accepted while data pending");
endmodule

bind fmi_top fmi_top_assertions #(.LANES(LANES), .PWM_W(PWM_W)) fmi_top_assertions_i (.*);

`default_nettype wire

// File: tb/test_fault_manager_interlock.sv
`timescale 1ns/1ps
`default_nettype none
`include "fmi_regs.svh"

module test_fault_manager_interlock;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 4'h0;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, link_fault_i = 1'b0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [15:0] fault_feedback_lanes_i, trip = 16'h0, pol_m = 16'h0;
  logic ext_critical_fault_in_n_i, ext_trip = 1'b0, critical_fault_out_n_o, link_fault_o;
  logic [31:0] pwm_i = 32'h0, pwm_o, pwm_d1 = 32'h0, mon_m, pwm_hold;
  logic [65:0] exp_q[$], mon_e;
  int num_errors = 0, n_tests = 0;

  fmi_top #(.LANES(16), .PWM_W(32)) fmi_top_i (.*);
  fmi_fault_src fmi_fault_src_i (.trip_i(trip), .pol_i(pol_m), .ext_trip_i(ext_trip),
    .lanes_o(fault_feedback_lanes_i), .ext_n_o(ext_critical_fault_in_n_i));

  // Free-running clock and random modulator traffic with its delayed copy
  always #4 ref_clk_i = ~ref_clk_i;
  // Seeded in the drawing process itself, otherwise the seed would not reach pwm_i
  initial begin
    void'($urandom(32'h9023));
    forever begin
      @(posedge ref_clk_i);
      pwm_d1 <= pwm_i;
      pwm_i <= $urandom;
    end
  end

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Responses are matched in order against the notes left by the bus tasks
  always @(posedge ref_clk_i) begin
    if (s_axi_bvalid_o === 1'b1 && s_axi_bready_i === 1'b1) begin
      mon_e = exp_q.pop_front();
      chk("bresp", {s_axi_bresp_o, 32'h0}, mon_e[33:0]);
    end
    if (s_axi_rvalid_o === 1'b1 && s_axi_rready_i === 1'b1) begin
      mon_e = exp_q.pop_front();
      mon_m = mon_e[65:34];
      chk("read", {s_axi_rresp_o, s_axi_rdata_o & mon_m}, {mon_e[33:32], mon_e[31:0] & mon_m});
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
                    input logic [1:0] r = fmi_pkg::FMI_RESP_OKAY);
    bit pa;
    bit pw;
    exp_q.push_back({32'h0, r, 32'h0});
    @(posedge ref_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= s;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    // Each channel is released only at the edge that takes it
    while (pa || pw) begin
      @(posedge ref_clk_i);
      if (pa && s_axi_awready_o === 1'b1) begin
        s_axi_awvalid_i <= 1'b0;
        pa = 1'b0;
      end
      if (pw && s_axi_wready_o === 1'b1) begin
        s_axi_wvalid_i <= 1'b0;
        pw = 1'b0;
      end
    end
    s_axi_bready_i <= 1'b1;
    do @(posedge ref_clk_i); while (s_axi_bvalid_o !== 1'b1);
    s_axi_bready_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] r = fmi_pkg::FMI_RESP_OKAY);
    exp_q.push_back({m, r, d});
    @(posedge ref_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    do @(posedge ref_clk_i); while (s_axi_arready_o !== 1'b1);
    s_axi_arvalid_i <= 1'b0;
    s_axi_rready_i <= 1'b1;
    do @(posedge ref_clk_i); while (s_axi_rvalid_o !== 1'b1);
    s_axi_rready_i <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenario helpers
  // ----------------------------------------------------------------
  task automatic pwm_chk(input bit blocked);
    repeat (2) begin
      @(posedge ref_clk_i);
      chk("pwm", {2'b0, pwm_o}, blocked ? 34'h0 : {2'b0, pwm_d1});
    end
  endtask

  // Four edges after the pin change cover the three-edge reaction
  task automatic tripped(input bit own);
    repeat (4) @(posedge ref_clk_i);
    pwm_chk(1'b1);
    chk("flt_out_n", {33'h0, critical_fault_out_n_o}, {33'h0, !own});
    chk("link_out", {33'h0, link_fault_o}, {33'h0, own});
  endtask

  // Release every source, clear the sticky flags and restart the outputs
  task automatic recover(input logic [31:0] lat, input bit via_ctrl);
    rd(`FMI_LATCH_OFS, lat, 32'h3ffff);
    rd(`FMI_STATUS_OFS, 32'hc, 32'hf);
    rd(`FMI_CTRL_OFS, 32'h6, 32'h7);
    trip <= 16'h0;
    ext_trip <= 1'b0;
    link_fault_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    if (via_ctrl) wr(`FMI_CTRL_OFS, 32'h106);
    else wr(`FMI_LATCH_OFS, 32'hffffffff);
    rd(`FMI_LATCH_OFS, 32'h0, 32'h3ffff);
    rd(`FMI_STATUS_OFS, 32'h1, 32'h7);
    wr(`FMI_CTRL_OFS, 32'h7);
    repeat (3) @(posedge ref_clk_i);
    pwm_chk(1'b0);
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // A full run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    num_errors++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(`FMI_CTRL_OFS, 32'h6, 32'h7);
    rd(`FMI_MASK_OFS, 32'hffff, 32'hffff);
    rd(`FMI_POL_OFS, 32'h0, 32'hffff);
    rd(`FMI_STATUS_OFS, 32'h1, 32'h7);
    pwm_chk(1'b1);
    rd(8'h40, 32'h0, 32'hffffffff, fmi_pkg::FMI_RESP_SLVERR);
    wr(8'h40, 32'h1, 4'hf, fmi_pkg::FMI_RESP_SLVERR);
    wr(`FMI_VALUES_OFS, 32'hffffffff);
    rd(`FMI_VALUES_OFS, 32'h0, 32'h3ffff);
    wr(`FMI_CTRL_OFS, 32'h7);
    repeat (3) @(posedge ref_clk_i);
    pwm_chk(1'b0);
    rd(`FMI_STATUS_OFS, 32'h2, 32'h7);
    // Clock enable low freezes the gated output while the modulators keep running
    ce_i <= 1'b0;
    @(posedge ref_clk_i);
    pwm_hold = pwm_o;
    repeat (4) @(posedge ref_clk_i);
    chk("ce_hold", {2'b0, pwm_o}, {2'b0, pwm_hold});
    ce_i <= 1'b1;
    // First and last lane trip the block
    for (int i = 0; i < 16; i += 15) begin
      trip <= 16'h1 << i;
      tripped(1'b1);
      rd(`FMI_VALUES_OFS, 32'h1 << i, 32'h3ffff);
      recover(32'h1 << i, 1'b0);
    end
    // A masked lane shows its level but never trips
    wr(`FMI_MASK_OFS, 32'hffdf);
    trip <= 16'h0020;
    repeat (4) @(posedge ref_clk_i);
    pwm_chk(1'b0);
    chk("flt_out_n", {33'h0, critical_fault_out_n_o}, 34'h1);
    rd(`FMI_VALUES_OFS, 32'h20, 32'h3ffff);
    rd(`FMI_RAW_OFS, 32'h20, 32'hffff);
    rd(`FMI_LATCH_OFS, 32'h0, 32'h3ffff);
    trip <= 16'h0;
    wr(`FMI_MASK_OFS, 32'h0, 4'h2);
    rd(`FMI_MASK_OFS, 32'hdf, 32'hffff);
    wr(`FMI_MASK_OFS, 32'hffff);
    // Turning a low lane active low trips it
    wr(`FMI_POL_OFS, 32'h80);
    tripped(1'b1);
    rd(`FMI_VALUES_OFS, 32'h80, 32'h3ffff);
    pol_m <= 16'h0080;
    recover(32'h80, 1'b0);
    // External and link interlocks block without echoing outward
    ext_trip <= 1'b1;
    tripped(1'b0);
    rd(`FMI_VALUES_OFS, 32'h10000, 32'h30000);
    recover(32'h10000, 1'b1);
    link_fault_i <= 1'b1;
    tripped(1'b0);
    rd(`FMI_VALUES_OFS, 32'h20000, 32'h30000);
    recover(32'h20000, 1'b0);
    end_of_test();
  end
endmodule

`default_nettype wire

// File: verilog/fmi_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Two-stage synchroniser bank for asynchronous pins
// ----------------------------------------------------------------
module fmi_sync #(
  parameter int W = 18
) (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // First stage is read only by the second stage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (en_i) begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;

endmodule
`default_nettype wire

// File: verilog/fmi_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fmi_regs.svh"

module fmi_top #(
  parameter int LANES = 16,
  parameter int PWM_W = 32
) (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // AXI4-Lite write address
  input wire logic [`FMI_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read address
  input wire logic [`FMI_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Fault pins and link interlock
  input wire logic [LANES-1:0] fault_feedback_lanes_i,
  input wire logic ext_critical_fault_in_n_i,
  input wire logic link_fault_i,
  output logic critical_fault_out_n_o,
  output logic link_fault_o,
  // PWM path
  input wire logic [PWM_W-1:0] pwm_i,
  output logic [PWM_W-1:0] pwm_o
);

  localparam int SRC = LANES + 2;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Address lies inside the register map
  function automatic logic addr_hit(input logic [`FMI_ADDR_W-1:0] a);
    return (a == `FMI_CTRL_OFS) || (a == `FMI_MASK_OFS) || (a == `FMI_POL_OFS) ||
           (a == `FMI_VALUES_OFS) || (a == `FMI_RAW_OFS) || (a == `FMI_LATCH_OFS) ||
           (a == `FMI_STATUS_OFS);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [SRC-1:0] pin_raw;
  logic [SRC-1:0] pin_sync;
  logic [LANES-1:0] lane_lvl;
  logic ext_act;
  logic link_act;

  // Inverting the interlock before the first stage keeps its reset value harmless
  assign pin_raw = {link_fault_i, ~ext_critical_fault_in_n_i, fault_feedback_lanes_i};

  fmi_sync #(
    .W(SRC)
  ) u_sync (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .en_i(ce_i),
    .d_i(pin_raw),
    .q_o(pin_sync)
  );

  assign lane_lvl = pin_sync[LANES-1:0]; // [R1]
  assign ext_act = pin_sync[`FMI_SRC_EXT_BIT]; // [R7]
  assign link_act = pin_sync[`FMI_SRC_LINK_BIT]; // [R10]

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [2:0] ctrl_r;
  logic [2:0] ctrl_nxt;
  logic [LANES-1:0] mask_r;
  logic [LANES-1:0] mask_nxt;
  logic [LANES-1:0] pol_r;
  logic [LANES-1:0] pol_nxt;
  logic [SRC-1:0] lat_r;
  logic [SRC-1:0] lat_nxt;
  fmi_pkg::fmi_state_t state_r;
  fmi_pkg::fmi_state_t state_nxt;
  logic [PWM_W-1:0] pwm_r;
  logic [PWM_W-1:0] pwm_nxt;
  logic flt_out_n_r;
  logic link_out_r;
  logic block_r;

  // ----------------------------------------------------------------
  // Fault sources
  // ----------------------------------------------------------------
  logic [LANES-1:0] lane_act;
  logic [LANES-1:0] lane_trig;
  logic [SRC-1:0] src_act;
  logic [SRC-1:0] src_trig;
  logic int_fault;
  logic fault_now;
  logic block;

  // Polarity bit set means the lane is active low
  assign lane_act = lane_lvl ^ pol_r; // [R4]
  // A masked lane still shows its flag but never trips the manager
  assign lane_trig = lane_act & mask_r; // [R5]
  assign src_act = {link_act, ext_act, lane_act}; // [R6]
  assign src_trig = {link_act & ctrl_r[`FMI_CTRL_LINK_EN_BIT],
                     ext_act & ctrl_r[`FMI_CTRL_ILK_EN_BIT],
                     lane_trig}; // [R2]
  // Only own lanes count as internal, so a ring of boards cannot latch itself up
  assign int_fault = |lane_trig || |lat_r[LANES-1:0]; // [R8] [R9]
  assign fault_now = |src_trig; // [R3] [R7]
  assign block = fault_now || (state_nxt != fmi_pkg::FMI_RUN); // [R2]

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic aw_got_r;
  logic w_got_r;
  logic [`FMI_ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;

  // Handshakes and write decode
  wire aw_hs = s_axi_awvalid_i && awready_r;
  wire w_hs = s_axi_wvalid_i && wready_r;
  wire ar_hs = s_axi_arvalid_i && arready_r;
  wire do_wr = aw_got_r && w_got_r && !bvalid_r;
  wire wr_ctrl = do_wr && (aw_addr_r == `FMI_CTRL_OFS);
  wire wr_mask = do_wr && (aw_addr_r == `FMI_MASK_OFS);
  wire wr_pol = do_wr && (aw_addr_r == `FMI_POL_OFS);
  wire wr_lat = do_wr && (aw_addr_r == `FMI_LATCH_OFS);
  wire [31:0] ctrl_wr = strb_merge({8'h00, 8'h00, 8'h00, 5'h00, ctrl_r}, w_data_r, w_strb_r);
  wire [31:0] mask_wr = strb_merge({16'h0000, mask_r}, w_data_r, w_strb_r);
  wire [31:0] pol_wr = strb_merge({16'h0000, pol_r}, w_data_r, w_strb_r);
  wire [31:0] lat_wr = strb_merge(32'h0000_0000, w_data_r, w_strb_r);
  wire clr_all = wr_ctrl && ctrl_wr[`FMI_CTRL_CLR_BIT];
  wire [SRC-1:0] lat_clr = clr_all ? {SRC{1'b1}} : (wr_lat ? lat_wr[SRC-1:0] : '0);

  // Channel flow: each address/data channel takes one item per transaction
  wire aw_got_nxt = (aw_got_r || aw_hs) && !do_wr;
  wire w_got_nxt = (w_got_r || w_hs) && !do_wr;
  wire bvalid_nxt = do_wr || (bvalid_r && !s_axi_bready_i);
  wire rvalid_nxt = ar_hs || (rvalid_r && !s_axi_rready_i);

  // Read data selection
  logic [31:0] rd_mux;
  assign rd_mux =
    (s_axi_araddr_i == `FMI_CTRL_OFS) ? {29'h0000_0000, ctrl_r} :
    (s_axi_araddr_i == `FMI_MASK_OFS) ? {16'h0000, mask_r} :
    (s_axi_araddr_i == `FMI_POL_OFS) ? {16'h0000, pol_r} :
    (s_axi_araddr_i == `FMI_VALUES_OFS) ? {14'h0000, src_act} : // [R6]
    (s_axi_araddr_i == `FMI_RAW_OFS) ? {16'h0000, lane_lvl} : // [R1]
    (s_axi_araddr_i == `FMI_LATCH_OFS) ? {14'h0000, lat_r} :
    (s_axi_araddr_i == `FMI_STATUS_OFS) ? {28'h000_0000, block_r, state_r} :
    32'h0000_0000;

  // Address and data holding
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (ce_i) begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      if (aw_hs) aw_addr_r <= s_axi_awaddr_i;
      if (w_hs) w_data_r <= s_axi_wdata_i;
      if (w_hs) w_strb_r <= s_axi_wstrb_i;
    end
  end

  // Ready and response flags, all straight from flops
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'b00;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
    end else if (ce_i) begin
      awready_r <= !aw_got_nxt && !bvalid_nxt;
      wready_r <= !w_got_nxt && !bvalid_nxt;
      bvalid_r <= bvalid_nxt;
      if (do_wr) bresp_r <= addr_hit(aw_addr_r) ? fmi_pkg::FMI_RESP_OKAY :
                                                  fmi_pkg::FMI_RESP_SLVERR;
      arready_r <= !rvalid_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // Read data captured when the address is taken
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'b00;
    end else if (ce_i && ar_hs) begin
      rdata_r <= rd_mux;
      rresp_r <= addr_hit(s_axi_araddr_i) ? fmi_pkg::FMI_RESP_OKAY :
                                            fmi_pkg::FMI_RESP_SLVERR;
    end
  end

  // ----------------------------------------------------------------
  // Configuration and sticky flags
  // ----------------------------------------------------------------

  // Run is dropped by hardware on a trip so software must re-arm on purpose
  always_comb begin
    ctrl_nxt = wr_ctrl ? ctrl_wr[2:0] : ctrl_r;
    if (state_r == fmi_pkg::FMI_RUN && fault_now) begin
      ctrl_nxt[`FMI_CTRL_RUN_BIT] = 1'b0;
    end
  end

  assign mask_nxt = wr_mask ? mask_wr[LANES-1:0] : mask_r; // [R5]
  assign pol_nxt = wr_pol ? pol_wr[LANES-1:0] : pol_r; // [R4]
  // An enabled source active in the clearing cycle keeps its flag set
  assign lat_nxt = (lat_r & ~lat_clr) | src_trig;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= `FMI_CTRL_RST;
      mask_r <= `FMI_MASK_RST;
      pol_r <= `FMI_POL_RST;
      lat_r <= '0;
    end else if (ce_i) begin
      ctrl_r <= ctrl_nxt;
      mask_r <= mask_nxt;
      pol_r <= pol_nxt;
      lat_r <= lat_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Execution state
  // ----------------------------------------------------------------

  // Leaving FAULT needs every sticky flag cleared and no enabled source active
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      fmi_pkg::FMI_IDLE: begin
        if (ctrl_r[`FMI_CTRL_RUN_BIT] && !fault_now && lat_r == '0) begin
          state_nxt = fmi_pkg::FMI_RUN;
        end
      end
      fmi_pkg::FMI_RUN: begin
        if (fault_now) begin
          state_nxt = fmi_pkg::FMI_FAULT; // [R2]
        end else if (!ctrl_r[`FMI_CTRL_RUN_BIT]) begin
          state_nxt = fmi_pkg::FMI_IDLE;
        end
      end
      fmi_pkg::FMI_FAULT: begin
        if (!fault_now && lat_r == '0) begin
          state_nxt = fmi_pkg::FMI_IDLE;
        end
      end
      default: begin
        state_nxt = fmi_pkg::FMI_FAULT;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= fmi_pkg::FMI_IDLE;
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // PWM gate and interlock outputs
  // ----------------------------------------------------------------

  // Two sync stages plus this flop give three cycles, well inside both budgets
  assign pwm_nxt = block ? '0 : pwm_i; // [R3] [R7] [R11]

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwm_r <= '0;
      block_r <= 1'b1;
      flt_out_n_r <= 1'b1;
      link_out_r <= 1'b0;
    end else if (ce_i) begin
      pwm_r <= pwm_nxt;
      block_r <= block;
      flt_out_n_r <= !int_fault; // [R8] [R9]
      link_out_r <= int_fault; // [R10]
    end
  end

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------
  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o = wready_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rresp_o = rresp_r;
  assign s_axi_rdata_o = rdata_r;
  assign pwm_o = pwm_r;
  assign critical_fault_out_n_o = flt_out_n_r;
  assign link_fault_o = link_out_r;

endmodule
`default_nettype wire
